// ==== design/pin_irq_pkg.sv ====
// types shared by the pin and interrupt mask block
package pin_irq_pkg;
    // fault events of one card slot, one-cycle pulses
    typedef struct packed {
        logic premature;
        logic timeout;
        logic overcurrent;
        logic supply_fail;
    } card_events_t;

    // register access from the serial slave front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// ==== design/pin_irq_regs.sv ====
// pin level/output registers, interrupt masks and interrupt status summary
`timescale 1ns/1ps
`include "pin_irq_regs.svh"
// ==========================================================
module pin_irq_regs #(
    parameter int PINS = 4
) (
    // clock, reset, enable
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic CLK_EN_IN,
    // register access
    input wire pin_irq_pkg::reg_req_t REQ_IN,
    output logic [7:0] RDATA_OUT,
    // card and system events, one-cycle pulses
    input wire pin_irq_pkg::card_events_t USER_EV_IN,
    input wire pin_irq_pkg::card_events_t MOD1_EV_IN,
    input wire pin_irq_pkg::card_events_t MOD2_EV_IN,
    input wire pin_irq_pkg::card_events_t MOD3_EV_IN,
    input wire logic PRESENCE_EV_IN,
    input wire logic SYNC_DONE_EV_IN,
    input wire logic THERMAL_EV_IN,
    input wire logic SUPERVISOR_EV_IN,
    // general purpose pins
    input wire logic [PINS-1:0] PIN_LEVEL_IN,
    output logic [PINS-1:0] PIN_LEVEL_OUT,
    output logic [PINS-1:0] PIN_OE_OUT,
    // interrupt pin, active low
    output logic IRQ_N_OUT
);
    logic [PINS-1:0] pin_out_q;
    logic [7:0] settings_q;
    logic [7:0] user_mask_q;
    logic [7:0] mod12_mask_q;
    logic [7:0] mod3_mask_q;
    logic [7:0] status_q;
    logic [7:0] rdata_q;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic [PINS-1:0] prev_q;
    logic [PINS-1:0] dir_in;
    logic [PINS-1:0] pin_change;
    logic [7:0] set_ev;
    logic clr_status;
    logic wr;
    logic [1:0] fill_q;
    // one write strobe per writable register, each already qualified by the clock enable
    logic wr_pin;
    logic wr_settings;
    logic wr_user_mask;
    logic wr_mod12_mask;
    logic wr_mod3_mask;

    assign wr = REQ_IN.wr & CLK_EN_IN;
    assign dir_in = settings_q[`DIR_MSB:`DIR_LSB];
    assign clr_status = CLK_EN_IN & REQ_IN.rd & (REQ_IN.addr == `ADDR_IRQ_STATUS);

    // address decode; the status register has no strobe, so writes to it are dropped
    assign wr_pin = wr & (REQ_IN.addr == `ADDR_PIN_LEVEL);
    assign wr_settings = wr & (REQ_IN.addr == `ADDR_DEV_SETTINGS);
    assign wr_user_mask = wr & (REQ_IN.addr == `ADDR_USER_MASK);
    assign wr_mod12_mask = wr & (REQ_IN.addr == `ADDR_MOD12_MASK);
    assign wr_mod3_mask = wr & (REQ_IN.addr == `ADDR_MOD3_PIN_MASK);

    // ==========================================================
    // pin input path
    // two-flop synchroniser; the third stage gives a clean edge reference
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else if (CLK_EN_IN) begin
            sync1_q <= PIN_LEVEL_IN;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // pin changes are not reported, whatever the edge reference holds, until the chain has filled;
    // without this a pin held high through reset would report a change once set as input
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            fill_q <= '0;
        end else if (CLK_EN_IN && fill_q != `SYNC_FILL) begin
            fill_q <= fill_q + 2'h1;
        end
    end

    // only pins set as input report a change
    assign pin_change = (sync2_q ^ prev_q) & dir_in & {PINS{fill_q == `SYNC_FILL}};

    // pin drivers: output level on every pin, driver enabled only where the direction bit says output
    assign PIN_LEVEL_OUT = pin_out_q;
    assign PIN_OE_OUT = ~dir_in;

    // ==========================================================
    // writable registers
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            pin_out_q <= `PIN_OUT_RESET;
        end else if (wr_pin) begin
            pin_out_q <= REQ_IN.wdata[PINS-1:0]; // upper bits are not stored
        end
    end

    // device settings hold the direction bits plus the boost enable kept as storage
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            settings_q <= `SETTINGS_RESET;
        end else if (wr_settings) begin
            settings_q <= REQ_IN.wdata & `SETTINGS_RW_MASK;
        end
    end

    // user card mask, which also holds the system event and all-pins masks
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            user_mask_q <= `MASK_RESET;
        end else if (wr_user_mask) begin
            user_mask_q <= REQ_IN.wdata;
        end
    end

    // first and second module mask, including both supply fail masks
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            mod12_mask_q <= `MASK_RESET;
        end else if (wr_mod12_mask) begin
            mod12_mask_q <= REQ_IN.wdata;
        end
    end

    // third module and per-pin mask; bit 0 is not defined and always reads zero
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            mod3_mask_q <= `MASK_RESET;
        end else if (wr_mod3_mask) begin
            mod3_mask_q <= REQ_IN.wdata & `MOD3_RW_MASK;
        end
    end

    // ==========================================================
    // masked event gating into the summary bits
    // a masked event is dropped outright; clearing the mask later raises nothing
    always_comb begin
        set_ev = '0;
        // user card faults, its supply fail and presence change share one summary bit
        set_ev[`ST_USER] = (USER_EV_IN.premature & ~user_mask_q[`UM_PREMATURE])
            | (USER_EV_IN.timeout & ~user_mask_q[`UM_TIMEOUT])
            | (USER_EV_IN.overcurrent & ~user_mask_q[`UM_OVERCURRENT])
            | (USER_EV_IN.supply_fail & ~mod12_mask_q[`M12_USER_SUPPLY])
            | (PRESENCE_EV_IN & ~user_mask_q[`UM_PRESENCE]);
        // modules one and two keep their masks side by side in one register
        set_ev[`ST_MOD1] = (MOD1_EV_IN.premature & ~mod12_mask_q[`M12_M1_PREMATURE])
            | (MOD1_EV_IN.timeout & ~mod12_mask_q[`M12_M1_TIMEOUT])
            | (MOD1_EV_IN.overcurrent & ~mod12_mask_q[`M12_M1_OVERCURRENT])
            | (MOD1_EV_IN.supply_fail & ~mod12_mask_q[`M12_MODS_SUPPLY]);
        set_ev[`ST_MOD2] = (MOD2_EV_IN.premature & ~mod12_mask_q[`M12_M2_PREMATURE])
            | (MOD2_EV_IN.timeout & ~mod12_mask_q[`M12_M2_TIMEOUT])
            | (MOD2_EV_IN.overcurrent & ~mod12_mask_q[`M12_M2_OVERCURRENT])
            | (MOD2_EV_IN.supply_fail & ~mod12_mask_q[`M12_MODS_SUPPLY]);
        // module three faults sit in the pin mask register; its supply fail shares one bit
        set_ev[`ST_MOD3] = (MOD3_EV_IN.premature & ~mod3_mask_q[`M3_PREMATURE])
            | (MOD3_EV_IN.timeout & ~mod3_mask_q[`M3_TIMEOUT])
            | (MOD3_EV_IN.overcurrent & ~mod3_mask_q[`M3_OVERCURRENT])
            | (MOD3_EV_IN.supply_fail & ~mod12_mask_q[`M12_MODS_SUPPLY]);
        // system events each have their own bit in the user card mask
        set_ev[`ST_THERM] = THERMAL_EV_IN & ~user_mask_q[`UM_THERMAL];
        set_ev[`ST_SUPV] = SUPERVISOR_EV_IN & ~user_mask_q[`UM_SUPERVISOR];
        set_ev[`ST_SYNC] = SYNC_DONE_EV_IN & ~user_mask_q[`UM_SYNC_DONE];
        // pin i is masked by bit i+1; the all-pins mask overrides every pin mask
        set_ev[`ST_PIN] = ~user_mask_q[`UM_ALL_PINS]
            & |(pin_change & ~mod3_mask_q[`M3_PIN_LSB + PINS - 1:`M3_PIN_LSB]);
    end

    // sticky summary bits; an event in the read cycle survives the clear
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            status_q <= '0;
        end else if (CLK_EN_IN) begin
            status_q <= (clr_status ? 8'h00 : status_q) | set_ev;
        end
    end

    assign IRQ_N_OUT = ~|status_q;

    // ==========================================================
    // read data, registered one cycle after the read strobe
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            rdata_q <= '0;
        end else if (CLK_EN_IN && REQ_IN.rd) begin
            unique case (REQ_IN.addr)
                `ADDR_IRQ_STATUS: rdata_q <= status_q;
                `ADDR_DEV_SETTINGS: rdata_q <= settings_q;
                `ADDR_PIN_LEVEL: rdata_q <= {sync2_q, pin_out_q};
                `ADDR_USER_MASK: rdata_q <= user_mask_q;
                `ADDR_MOD12_MASK: rdata_q <= mod12_mask_q;
                `ADDR_MOD3_PIN_MASK: rdata_q <= mod3_mask_q;
                default: rdata_q <= 8'h00; // unmapped here reads zero
            endcase
        end
    end

    assign RDATA_OUT = rdata_q;
endmodule

// ==== design/pin_irq_regs.svh ====
// register offsets, field positions and reset values for the pin and interrupt mask block
`ifndef PIN_IRQ_REGS_SVH
`define PIN_IRQ_REGS_SVH
`define ADDR_IRQ_STATUS 8'h41
`define ADDR_DEV_SETTINGS 8'h42
`define ADDR_PIN_LEVEL 8'h43
`define ADDR_USER_MASK 8'h44
`define ADDR_MOD12_MASK 8'h45
`define ADDR_MOD3_PIN_MASK 8'h46
`define PIN_OUT_RESET 4'hF
`define MASK_RESET 8'h00
`define DIR_RESET 4'h0
`define DIR_LSB 2
`define DIR_MSB 5
`define SETTINGS_RESET 8'h80
`define SETTINGS_RW_MASK 8'hBC
`define MOD3_RW_MASK 8'hFE
`define ST_USER 7
`define ST_MOD1 6
`define ST_MOD2 5
`define ST_MOD3 4
`define ST_THERM 3
`define ST_SUPV 2
`define ST_SYNC 1
`define ST_PIN 0
`define UM_PREMATURE 7
`define UM_TIMEOUT 6
`define UM_OVERCURRENT 5
`define UM_SYNC_DONE 4
`define UM_THERMAL 3
`define UM_SUPERVISOR 2
`define UM_ALL_PINS 1
`define UM_PRESENCE 0
`define M12_M1_PREMATURE 7
`define M12_M1_TIMEOUT 6
`define M12_M1_OVERCURRENT 5
`define M12_M2_PREMATURE 4
`define M12_M2_TIMEOUT 3
`define M12_M2_OVERCURRENT 2
`define M12_MODS_SUPPLY 1
`define M12_USER_SUPPLY 0
`define M3_PREMATURE 7
`define M3_TIMEOUT 6
`define M3_OVERCURRENT 5
`define M3_PIN_LSB 1
`define SYNC_FILL 2'h3
`endif

// ==== verification/gpio_and_interrupt_mask_regs_test.sv ====
// self-checking bench for the pin and interrupt mask block
`timescale 1ns/1ps
module gpio_and_interrupt_mask_regs_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [19:0] ev = '0;
    logic [3:0] pins = 4'h0;
    logic [7:0] d;
    logic [7:0] rdata;
    logic pend = 1'b0;
    pin_irq_pkg::reg_req_t req;
    logic [7:0] exp_q[$];
    logic [7:0] adr_q[$];
    int n_fail = 0;
    int checks_done = 0;
    // per event: mask address and bit, then summary status bit
    logic [11:0] msk[20] = '{12'h450, 12'h445, 12'h446, 12'h447, 12'h451, 12'h455, 12'h456,
        12'h457, 12'h451, 12'h452, 12'h453, 12'h454, 12'h451, 12'h465, 12'h466, 12'h467,
        12'h440, 12'h444, 12'h443, 12'h442};
    int st[20] = '{7, 7, 7, 7, 6, 6, 6, 6, 5, 5, 5, 5, 4, 4, 4, 4, 7, 1, 3, 2};
    always #2.5 clk = ~clk;
    host_model host (.clk(clk), .req(req));
    pin_irq_regs dut (.CLOCK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(clk_en), .REQ_IN(req),
        .RDATA_OUT(rdata), .USER_EV_IN(ev[3:0]), .MOD1_EV_IN(ev[7:4]), .MOD2_EV_IN(ev[11:8]),
        .MOD3_EV_IN(ev[15:12]), .PRESENCE_EV_IN(ev[16]), .SYNC_DONE_EV_IN(ev[17]),
        .THERMAL_EV_IN(ev[18]), .SUPERVISOR_EV_IN(ev[19]), .PIN_LEVEL_IN(pins),
        .PIN_LEVEL_OUT(), .PIN_OE_OUT(), .IRQ_N_OUT());
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        adr_q.push_back(a);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 20'h1 << i;
        @(posedge clk);
        ev <= '0;
    endtask
    // a read answers one cycle later; compare after that edge has settled
    always @(posedge clk) pend <= req.rd && !rst;
    always @(negedge clk) begin
        if (pend) begin
            check($sformatf("read %h", adr_q.pop_front()), rdata, exp_q.pop_front());
        end
    end
    initial begin
        #40000;
        n_fail++;
        give_verdict;
    end
    initial begin
        void'($urandom(5117));
        pins = $urandom;
        d = $urandom;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // reset values, refused writes, unmapped address
        host.access(1'b1, 8'h41, 8'hFF);
        host.access(1'b1, 8'h46, 8'hFF);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h80);
        rd(8'h43, {pins, 4'hF});
        rd(8'h44, 8'h00);
        rd(8'h45, 8'h00);
        rd(8'h46, 8'hFE);
        rd(8'h47, 8'h00);
        host.access(1'b1, 8'h46, 8'h00);
        host.access(1'b1, 8'h43, d);
        rd(8'h43, {pins, d[3:0]});
        // every event source unmasked, then with its own mask bit set
        for (int i = 0; i < 20; i++) begin
            pulse(i);
            rd(8'h41, 8'h01 << st[i]);
            rd(8'h41, 8'h00);
            host.access(1'b1, msk[i][11:4], 8'h01 << msk[i][3:0]);
            pulse(i);
            rd(8'h41, 8'h00);
            host.access(1'b1, msk[i][11:4], 8'h00);
        end
        // settings keep only the direction bits and the stored boost bit
        host.access(1'b1, 8'h42, 8'hFF);
        rd(8'h42, 8'hBC);
        // pin change: plain, own mask, all-pins mask, output direction
        for (int j = 0; j < 4; j++) begin
            for (int k = 0; k < 4; k++) begin
                host.access(1'b1, 8'h46, k == 1 ? 8'h02 << j : 8'h00);
                host.access(1'b1, 8'h44, k == 2 ? 8'h02 : 8'h00);
                host.access(1'b1, 8'h42, k == 3 ? 8'h3C ^ (8'h04 << j) : 8'h3C);
                @(posedge clk);
                pins[j] <= ~pins[j];
                repeat (4) @(posedge clk);
                rd(8'h41, k == 0 ? 8'h01 : 8'h00);
            end
        end
        // clock enable low: the write and the event are both lost
        clk_en <= 1'b0;
        host.access(1'b1, 8'h44, 8'hFF);
        pulse(18);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(8'h44, 8'h00);
        rd(8'h41, 8'h00);
        rd(8'h43, {pins, d[3:0]});
        give_verdict;
    end
endmodule

// ==== verification/host_model.sv ====
// host side model issuing register accesses on the request port
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output pin_irq_pkg::reg_req_t req
);
    initial req = '0;
    // one request per call; on release wr and rd drop to zero and address and data show the inverse so stale values never pass
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{w, !w, a, d};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// ==== verification/pin_irq_regs_asserts.sv ====
// port-level checks for the pin and interrupt mask block
`timescale 1ns/1ps
module pin_irq_checks #(
    parameter int PINS = 4
) (
    // clock, reset, request
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic CLK_EN_IN,
    input wire pin_irq_pkg::reg_req_t REQ_IN,
    // events
    input wire pin_irq_pkg::card_events_t USER_EV_IN,
    input wire logic PRESENCE_EV_IN,
    input wire logic SYNC_DONE_EV_IN,
    input wire logic THERMAL_EV_IN,
    input wire logic SUPERVISOR_EV_IN,
    // outputs
    input wire logic [7:0] RDATA_OUT,
    input wire logic [PINS-1:0] PIN_LEVEL_OUT,
    input wire logic [PINS-1:0] PIN_OE_OUT,
    input wire logic IRQ_N_OUT
);
    // ====================================================
    // helpers
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    logic [7:0] um_q;
    wire en = CLK_EN_IN;
    wire wr42 = en && REQ_IN.wr && REQ_IN.addr == 8'h42;
    wire rd41 = en && REQ_IN.rd && REQ_IN.addr == 8'h41;
    // shadow of the user mask, so that only unmasked events are required to fire
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            um_q <= 8'h00;
        end else if (en && REQ_IN.wr && REQ_IN.addr == 8'h44) begin
            um_q <= REQ_IN.wdata;
        end
    end
    sequence s_irq_low;
        !IRQ_N_OUT;
    endsequence
    // ====================================================
    // assertions
    a_user_oc: assert property (en && USER_EV_IN.overcurrent && !um_q[5] |=> s_irq_low)
        else $error("overcurrent event lost");
    a_sync_irq: assert property (en && SYNC_DONE_EV_IN && !um_q[4] |=> s_irq_low)
        else $error("sync done event lost");
    a_thermal_irq: assert property (en && THERMAL_EV_IN && !um_q[3] |=> s_irq_low)
        else $error("thermal event lost");
    a_super_irq: assert property (en && SUPERVISOR_EV_IN && !um_q[2] |=> s_irq_low)
        else $error("supervisor event lost");
    a_presence_irq: assert property (en && PRESENCE_EV_IN && !um_q[0] |=> s_irq_low)
        else $error("presence event lost");
    a_irq_held: assert property (!IRQ_N_OUT && !rd41 |=> s_irq_low)
        else $error("interrupt dropped without status read");
    a_reset_outs: assert property ($fell(RESET_IN) |-> &PIN_LEVEL_OUT && &PIN_OE_OUT)
        else $error("pin outputs wrong after reset");
    a_dir_write: assert property (wr42 |=> PIN_OE_OUT == ~$past(REQ_IN.wdata[5:2]))
        else $error("direction write not applied");
    a_dir_hold: assert property (!wr42 |=> $stable(PIN_OE_OUT))
        else $error("direction changed without write");
    a_out_read: assert property (en && REQ_IN.rd && !REQ_IN.wr && REQ_IN.addr == 8'h43
        |=> RDATA_OUT[3:0] == $past(PIN_LEVEL_OUT)) else $error("output level read wrong");
endmodule
bind pin_irq_regs pin_irq_checks #(.PINS(PINS)) checks (.CLOCK_IN(CLOCK_IN),
    .RESET_IN(RESET_IN), .CLK_EN_IN(CLK_EN_IN), .REQ_IN(REQ_IN), .USER_EV_IN(USER_EV_IN),
    .PRESENCE_EV_IN(PRESENCE_EV_IN), .SYNC_DONE_EV_IN(SYNC_DONE_EV_IN),
    .THERMAL_EV_IN(THERMAL_EV_IN), .SUPERVISOR_EV_IN(SUPERVISOR_EV_IN),
    .RDATA_OUT(RDATA_OUT), .PIN_LEVEL_OUT(PIN_LEVEL_OUT), .PIN_OE_OUT(PIN_OE_OUT),
    .IRQ_N_OUT(IRQ_N_OUT));
